// file: hdl/pia_pkg.sv
`default_nettype none
// ************************************************************
// Constants of the priority interrupt arbiter
// ************************************************************
package pia_pkg;
  localparam int          NUM_SRC       = 64;
  localparam int          SRC_W         = 6;
  localparam int          ADDR_W        = 21;
  localparam int          BASE_W        = 15;
  // Register indices; byte address is four times the index
  localparam logic [6:0]  IDX_PRIO_0    = 7'h00;
  localparam logic [6:0]  IDX_PRIO_7    = 7'h17;
  localparam logic [6:0]  IDX_VBASE     = 7'h07;
  localparam logic [6:0]  IDX_FMATCH0   = 7'h08;
  localparam logic [6:0]  IDX_FVLOW0    = 7'h09;
  localparam logic [6:0]  IDX_FVHIGH0   = 7'h0a;
  localparam logic [6:0]  IDX_FMATCH1   = 7'h0b;
  localparam logic [6:0]  IDX_FVLOW1    = 7'h0c;
  localparam logic [6:0]  IDX_FVHIGH1   = 7'h0d;
  localparam logic [6:0]  IDX_PEND_0    = 7'h0e;
  localparam logic [6:0]  IDX_PEND_3    = 7'h11;
  localparam logic [6:0]  IDX_CTRL      = 7'h16;
  localparam logic [6:0]  IDX_ISTAT     = 7'h18;
  localparam logic [6:0]  IDX_IMASK     = 7'h19;
  // Control register field positions
  localparam int          CTRL_LVL_LSB  = 0;
  localparam int          CTRL_VALID    = 2;
  localparam int          CTRL_FAST     = 3;
  localparam int          CTRL_LOWPWR   = 4;
  // Interrupt status bits
  localparam int          ST_WAKE       = 0;
  localparam int          ST_FAST       = 1;
  // Reset values
  localparam logic [15:0] VBASE_RST     = 16'h0000;
  localparam logic [ADDR_W-1:0] BOOT_ADDR = 21'h000000;
  // Sources whose field encodes levels 1 to 3; all others 0 to 2
  localparam logic [63:0] HI_RANGE_SRC  = 64'h0000_0000_0000_00ff;
endpackage : pia_pkg
`default_nettype wire

// file: hdl/pia_lowest_enc.sv
`default_nettype none
// ************************************************************
// Lowest-index request finder
// ************************************************************
module pia_lowest_enc #(
  parameter int N = 64,
  parameter int W = 6
) (
  input  wire logic [N-1:0] req,
  output logic              found,
  output logic [W-1:0]      idx
);
  // Scan from the top so the lowest set index is kept last
  always_comb
  begin
    found = 1'b0;
    idx   = '0;
    for (int i = N - 1; i >= 0; i--)
    begin
      if (req[i])
      begin
        found = 1'b1;
        idx   = W'(i);
      end
    end
  end
endmodule : pia_lowest_enc
`default_nettype wire

// file: hdl/pia_arbiter.sv
`default_nettype none
// Notes on behaviour
// - Sixty-four sources, each programmable to off or to one of three of the four levels.
// - Within a level the lowest source number wins; 0 highest, 63 lowest.
// - Core is told a request is pending and given its service address.
// - Normal vector address is vector base concatenated with source number.
// - A request above the level being serviced may still be presented.
// - Presented-level field: 00 none, 01 level 0, 10 level 1, 11 level 2/3.
// - Level 2 winner matching a fast match value uses that fast vector pair.
// - Fast interrupts are recognised here, before the core fetches.
// - In wait or stop a pending request asks for clocks back.
// - Only sources enabled at wait or stop entry may wake.
// - Normal mode after reset; initial fetch address driven after reset.
// - Register slave on the peripheral bus at base plus offset.
// - Levels 1-3 fields: 00 off, 01 one, 10 two, 11 three.
// - Levels 0-2 fields: 00 off, 01 zero, 10 one, 11 two.
module pia_arbiter (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [63:0] irq_src,
  input  wire logic        core_irq_ack,
  input  wire logic        core_irq_done,
  input  wire logic        low_power,
  output logic             core_irq_valid,
  output logic [1:0]       presented_level,
  output logic [20:0]      vector_addr,
  output logic             fast_sel,
  output logic             boot_addr_valid,
  output logic             wake_req,
  output logic             irq_out
);
  // ************************************************************
  // Register storage
  // ************************************************************
  logic [15:0] prio_reg [8];
  logic [15:0] vector_base_reg;
  logic [15:0] fast_match_zero_reg;
  logic [15:0] fast_match_one_reg;
  logic [15:0] fast_vector_low_reg [2];
  logic [15:0] fast_vector_high_reg [2];
  logic [1:0]  istat_reg;
  logic [1:0]  imask_reg;
  logic [1:0]  serviced_reg;
  logic [63:0] wake_en_reg;
  logic        low_power_reg;
  logic [31:0] prdata_reg;
  logic        pready_reg;
  logic        pslverr_reg;
  logic        valid_reg;
  logic [1:0]  level_reg;
  logic [20:0] vector_reg;
  logic        fast_reg;
  logic        boot_reg;
  logic        wake_reg;
  logic        irq_reg;

  // ************************************************************
  // Per-source level decode
  // ************************************************************
  logic [63:0] src_on;
  logic [63:0] lvl_req [4];
  logic [3:0]  lvl_found;
  logic [5:0]  lvl_idx [4];

  // Field to level; 00 disables the source without touching its request
  always_comb
  begin
    logic [1:0] fld;
    logic [1:0] lvl;
    fld = 2'h0;
    lvl = 2'h0;
    for (int l = 0; l < 4; l++)
      lvl_req[l] = 64'h0;
    for (int s = 0; s < pia_pkg::NUM_SRC; s++)
    begin
      fld       = prio_reg[s / 8][2 * (s % 8) +: 2];
      src_on[s] = (fld != 2'h0);
      lvl       = pia_pkg::HI_RANGE_SRC[s] ? fld : 2'(fld - 2'h1);
      if (src_on[s] && irq_src[s])
        lvl_req[lvl][s] = 1'b1;
    end
  end

  // One lowest-number finder per level
  for (genvar g = 0; g < 4; g++)
  begin : g_enc
    pia_lowest_enc #(.N(pia_pkg::NUM_SRC), .W(pia_pkg::SRC_W)) u_enc (
      .req   (lvl_req[g]),
      .found (lvl_found[g]),
      .idx   (lvl_idx[g])
    );
  end

  // ************************************************************
  // Arbitration between levels and vector choice
  // ************************************************************
  logic       top_found;
  logic [1:0] top_lvl;
  logic [5:0] top_idx;
  logic       nest_ok;
  logic       fast0_hit;
  logic       fast1_hit;
  logic [1:0] code_next;

  // Highest pending level wins
  always_comb
  begin
    top_found = 1'b0;
    top_lvl   = 2'h0;
    for (int l = 0; l < 4; l++)
    begin
      if (lvl_found[l])
      begin
        top_found = 1'b1;
        top_lvl   = 2'(l);
      end
    end
    top_idx = lvl_idx[top_lvl];
  end

  // Nesting: must reach the minimum level that the shown code allows
  assign nest_ok   = top_found && (top_lvl >= serviced_reg);
  assign fast0_hit = (top_lvl == 2'h2) && (top_idx == fast_match_zero_reg[5:0]);
  assign fast1_hit = (top_lvl == 2'h2) && (top_idx == fast_match_one_reg[5:0]);
  assign code_next = !nest_ok ? 2'h0 : (top_lvl == 2'h3) ? 2'h3 : 2'(top_lvl + 2'h1);

  // Presentation to the core; valid, code and fast flag refreshed every cycle, vector kept when nothing is shown
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      valid_reg  <= 1'b0;
      level_reg  <= 2'h0;
      vector_reg <= pia_pkg::BOOT_ADDR;
      fast_reg   <= 1'b0;
      boot_reg   <= 1'b1;
    end
    else
    begin
      boot_reg  <= 1'b0;
      valid_reg <= nest_ok;
      level_reg <= code_next;
      fast_reg  <= nest_ok && (fast0_hit || fast1_hit);
      if (nest_ok)
      begin
        if (fast0_hit)
          vector_reg <= {fast_vector_high_reg[0][4:0], fast_vector_low_reg[0]};
        else if (fast1_hit)
          vector_reg <= {fast_vector_high_reg[1][4:0], fast_vector_low_reg[1]};
        else
          vector_reg <= {vector_base_reg[14:0], top_idx};
      end
    end
  end

  // Level being serviced: taken on acknowledge, dropped on return
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      serviced_reg <= 2'h0;
    else if (core_irq_ack && valid_reg)
      serviced_reg <= level_reg;
    else if (core_irq_done)
      serviced_reg <= 2'h0;
  end

  // ************************************************************
  // Wait and stop wake-up
  // ************************************************************
  // Enables are frozen on entry; later disables still block
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      low_power_reg <= 1'b0;
      wake_en_reg   <= 64'h0;
      wake_reg      <= 1'b0;
    end
    else
    begin
      low_power_reg <= low_power;
      if (low_power && !low_power_reg)
        wake_en_reg <= src_on;
      wake_reg <= low_power && low_power_reg
                  && |(irq_src & wake_en_reg & src_on);
    end
  end

  // ************************************************************
  // APB slave
  // ************************************************************
  logic       acc_done;
  logic [6:0] idx;
  logic       wr_en;
  logic       rd_en;
  logic       mapped;
  logic [1:0] ev_set;

  assign acc_done = psel && penable && pready_reg;
  assign idx      = paddr[8:2];
  assign wr_en    = acc_done && pwrite;
  assign rd_en    = acc_done && !pwrite;
  assign mapped   = (paddr[11:9] == 3'h0) && (paddr[1:0] == 2'h0)
                    && ((idx <= pia_pkg::IDX_PEND_3) || (idx == pia_pkg::IDX_CTRL)
                    || (idx >= pia_pkg::IDX_PRIO_7 && idx <= pia_pkg::IDX_IMASK));

  // Read mux
  function automatic logic [31:0] pia_read(input logic [6:0] a);
    logic [31:0] d;
    d = 32'h0;
    if (a < pia_pkg::IDX_VBASE)
      d[15:0] = prio_reg[a[2:0]];
    unique case (a)
      pia_pkg::IDX_PRIO_7:   d[15:0] = prio_reg[7];
      pia_pkg::IDX_VBASE:    d[15:0] = vector_base_reg;
      pia_pkg::IDX_FMATCH0:  d[15:0] = fast_match_zero_reg;
      pia_pkg::IDX_FVLOW0:   d[15:0] = fast_vector_low_reg[0];
      pia_pkg::IDX_FVHIGH0:  d[15:0] = fast_vector_high_reg[0];
      pia_pkg::IDX_FMATCH1:  d[15:0] = fast_match_one_reg;
      pia_pkg::IDX_FVLOW1:   d[15:0] = fast_vector_low_reg[1];
      pia_pkg::IDX_FVHIGH1:  d[15:0] = fast_vector_high_reg[1];
      pia_pkg::IDX_CTRL:
      begin
        d[pia_pkg::CTRL_LVL_LSB +: 2] = level_reg;
        d[pia_pkg::CTRL_VALID]        = valid_reg;
        d[pia_pkg::CTRL_FAST]         = fast_reg;
        d[pia_pkg::CTRL_LOWPWR]       = low_power_reg;
      end
      pia_pkg::IDX_ISTAT:    d[1:0] = istat_reg;
      pia_pkg::IDX_IMASK:    d[1:0] = imask_reg;
      default:
        if (a >= pia_pkg::IDX_PEND_0 && a <= pia_pkg::IDX_PEND_3)
          d[15:0] = irq_src[16 * 2'(a - pia_pkg::IDX_PEND_0) +: 16];
    endcase
    return d;
  endfunction : pia_read

  // One wait state; answer and data come from flops
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0;
    end
    else
    begin
      pready_reg  <= psel && penable && !pready_reg;
      pslverr_reg <= psel && penable && !pready_reg && !mapped;
      if (psel && penable && !pready_reg)
        prdata_reg <= (mapped && !pwrite) ? pia_read(idx) : 32'h0;
    end
  end

  // Software-written configuration
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < 8; i++)
        prio_reg[i] <= 16'h0000;
      vector_base_reg     <= pia_pkg::VBASE_RST;
      fast_match_zero_reg <= 16'h0000;
      fast_match_one_reg  <= 16'h0000;
      fast_vector_low_reg[0]  <= 16'h0000;
      fast_vector_low_reg[1]  <= 16'h0000;
      fast_vector_high_reg[0] <= 16'h0000;
      fast_vector_high_reg[1] <= 16'h0000;
      imask_reg <= 2'h0;
    end
    else if (wr_en && mapped)
    begin
      if (idx < pia_pkg::IDX_VBASE)
        prio_reg[idx[2:0]] <= pwdata[15:0];
      unique case (idx)
        pia_pkg::IDX_PRIO_7:   prio_reg[7]             <= pwdata[15:0];
        pia_pkg::IDX_VBASE:    vector_base_reg         <= pwdata[15:0];
        pia_pkg::IDX_FMATCH0:  fast_match_zero_reg     <= pwdata[15:0];
        pia_pkg::IDX_FVLOW0:   fast_vector_low_reg[0]  <= pwdata[15:0];
        pia_pkg::IDX_FVHIGH0:  fast_vector_high_reg[0] <= pwdata[15:0];
        pia_pkg::IDX_FMATCH1:  fast_match_one_reg      <= pwdata[15:0];
        pia_pkg::IDX_FVLOW1:   fast_vector_low_reg[1]  <= pwdata[15:0];
        pia_pkg::IDX_FVHIGH1:  fast_vector_high_reg[1] <= pwdata[15:0];
        pia_pkg::IDX_IMASK:    imask_reg               <= pwdata[1:0];
        default: ;
      endcase
    end
  end

  // ************************************************************
  // Interrupt status, mask and output
  // ************************************************************
  assign ev_set[pia_pkg::ST_WAKE] = wake_reg;
  assign ev_set[pia_pkg::ST_FAST] = fast_reg;

  // Sticky events; read clears, a new event in the same cycle wins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      istat_reg <= 2'h0;
      irq_reg   <= 1'b0;
    end
    else
    begin
      if (rd_en && mapped && idx == pia_pkg::IDX_ISTAT)
        istat_reg <= ev_set;
      else
        istat_reg <= istat_reg | ev_set;
      irq_reg <= |(istat_reg & imask_reg);
    end
  end

  assign prdata          = prdata_reg;
  assign pready          = pready_reg;
  assign pslverr         = pslverr_reg;
  assign core_irq_valid  = valid_reg;
  assign presented_level = level_reg;
  assign vector_addr     = vector_reg;
  assign fast_sel        = fast_reg;
  assign boot_addr_valid = boot_reg;
  assign wake_req        = wake_reg;
  assign irq_out         = irq_reg;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  valid_follows_a: assert property (top_found && top_lvl >= serviced_reg |=> valid_reg)
    else $error("pending request not presented");
  normal_vector_a: assert property (nest_ok && !fast0_hit && !fast1_hit
      |=> vector_reg == {$past(vector_base_reg[14:0]), $past(top_idx)})
    else $error("normal vector address wrong");
  fast_vector_a: assert property (nest_ok && fast0_hit
      |=> fast_reg && vector_reg[15:0] == $past(fast_vector_low_reg[0]))
    else $error("fast vector not used");
  nest_block_a: assert property (top_found && top_lvl < serviced_reg |=> !valid_reg)
    else $error("lower level request presented");
  level_code_a: assert property (nest_ok && top_lvl == 2'h0 |=> level_reg == 2'h1)
    else $error("level code for level 0 wrong");
  lowest_wins_a: assert property (lvl_found[0] |-> lvl_req[0][lvl_idx[0]]
      && (lvl_req[0] & ((64'h1 << lvl_idx[0]) - 64'h1)) == 64'h0)
    else $error("lowest source not chosen");
  disabled_block_a: assert property (src_on == 64'h0 |=> !valid_reg)
    else $error("disabled source presented");
  wake_gate_a: assert property (!low_power |=> !wake_reg)
    else $error("wake outside low power");
  wake_enable_a: assert property (low_power && low_power_reg
      && |(irq_src & wake_en_reg & src_on) |=> wake_reg)
    else $error("enabled source did not wake");
  apb_answer_a: assert property (psel && penable && !pready_reg |=> pready_reg)
    else $error("bus answer late");
  set_wins_a: assert property (wake_reg |=> istat_reg[pia_pkg::ST_WAKE])
    else $error("wake event lost");
  nested_cov: cover property (valid_reg && core_irq_ack ##[1:20] valid_reg && level_reg == 2'h3);
  fast_cov: cover property (fast_reg && valid_reg);
  wake_cov: cover property (low_power ##[1:20] wake_reg);
endmodule : pia_arbiter
`default_nettype wire

// file: verif/pia_core_model.sv
`default_nettype none
// ************************************************************
// Core-side partner: accepts or returns from presented requests
// ************************************************************
module pia_core_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       core_irq_valid,
  input  wire logic       fast_sel,
  input  wire logic       fetched_jump,
  input  wire logic [1:0] presented_level,
  input  wire logic [1:0] core_mask,
  input  wire logic       take,
  input  wire logic       finish,
  output logic            core_irq_ack,
  output logic            core_irq_done,
  output logic            fast_mode
);
  timeunit 1ns;
  timeprecision 1ps;
  logic lvl_ok;

  // Mask 11 lets only the top code through, else code must exceed the mask
  assign lvl_ok = (core_mask == 2'h3) ? (presented_level == 2'h3)
                                      : (presented_level > core_mask);

  // One-cycle accept and return pulses, accept only while offered
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      core_irq_ack  <= 1'b0;
      core_irq_done <= 1'b0;
    end
    else
    begin
      core_irq_ack  <= take && core_irq_valid && lvl_ok;
      core_irq_done <= finish;
    end
  end

  // Fast handling starts on accept unless the fetched word is a subroutine jump
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      fast_mode <= 1'b0;
    else if (core_irq_ack && fast_sel && !fetched_jump)
      fast_mode <= 1'b1;
    else if (core_irq_done)
      fast_mode <= 1'b0;
  end
endmodule : pia_core_model
`default_nettype wire

// file: verif/test_priority_interrupt_arbiter.sv
`default_nettype none
module test_priority_interrupt_arbiter;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [63:0] irq_src;
  logic        ack, done, low_power, valid, fast_sel, boot_v, wake_req, irq_out;
  logic        take, finish, err, fast_mode;
  logic [1:0]  lvl;
  logic [20:0] vaddr;
  int          error_cnt, comparisons;

  // ************************************************************
  // Design, partner and clock
  // ************************************************************
  pia_arbiter u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq_src(irq_src), .core_irq_ack(ack), .core_irq_done(done),
    .low_power(low_power), .core_irq_valid(valid), .presented_level(lvl),
    .vector_addr(vaddr), .fast_sel(fast_sel), .boot_addr_valid(boot_v),
    .wake_req(wake_req), .irq_out(irq_out));
  pia_core_model u_core (.pclk(pclk), .presetn(presetn), .core_irq_valid(valid),
    .fast_sel(fast_sel), .fetched_jump(1'b0),
    .presented_level(lvl), .core_mask(2'h0), .take(take), .finish(finish),
    .core_irq_ack(ack), .core_irq_done(done), .fast_mode(fast_mode));

  // Free-running clock at 8 ns
  initial
  begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // ************************************************************
  // Tasks
  // ************************************************************
  task close_out;
    $display("Comparisons %0d, errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : close_out

  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // One APB transfer; pready is sampled at the rising edge that completes it
  task apb(input logic w, input logic [6:0] idx, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= {3'h0, idx, 2'h0};
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
    begin
      error_cnt++;
      close_out();
    end
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Let arbitration follow a change, then sample between edges
  task settle;
    repeat (4) @(posedge pclk);
    @(negedge pclk);
  endtask : settle

  task pulse(input logic which);
    @(posedge pclk);
    if (which) take <= 1'b1; else finish <= 1'b1;
    @(posedge pclk);
    take   <= 1'b0;
    finish <= 1'b0;
  endtask : pulse

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial
  begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
    pwdata = 32'h0; irq_src = 64'h0; low_power = 1'b0; take = 1'b0; finish = 1'b0;
    error_cnt = 0; comparisons = 0;
    repeat (6) @(posedge pclk);
    @(negedge pclk);
    chk("boot_valid", 32'h1, {31'h0, boot_v});
    chk("boot_addr", 32'h0, {11'h0, vaddr});
    @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, pia_pkg::IDX_VBASE, 32'h0);
    chk("vbase_rst", {16'h0, pia_pkg::VBASE_RST}, rd);
    apb(1'b0, 7'h12, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, err});
    chk("unmapped_data", 32'h0, rd);
    // Sources 9 and 12 at level 0, source 3 at level 3, source 20 at level 2
    apb(1'b1, pia_pkg::IDX_VBASE, 32'h1234);
    apb(1'b1, pia_pkg::IDX_PRIO_0 + 7'h1, 32'h0104);
    apb(1'b1, pia_pkg::IDX_PRIO_0, 32'h00c0);
    apb(1'b1, pia_pkg::IDX_PRIO_0 + 7'h2, 32'h0300);
    apb(1'b1, pia_pkg::IDX_FMATCH0, 32'h14);
    apb(1'b1, pia_pkg::IDX_FVLOW0, 32'habcd);
    apb(1'b1, pia_pkg::IDX_FVHIGH0, 32'h1f);
    apb(1'b1, pia_pkg::IDX_IMASK, 32'h1);
    irq_src[12] <= 1'b1;
    irq_src[9]  <= 1'b1;
    settle();
    chk("valid_l0", 32'h1, {31'h0, valid});
    chk("level_l0", 32'h1, {30'h0, lvl});
    chk("vec_l0", {11'h0, 15'h1234, 6'd9}, {11'h0, vaddr});
    @(posedge pclk);
    irq_src[3] <= 1'b1;
    settle();
    chk("level_l3", 32'h3, {30'h0, lvl});
    chk("vec_l3", {11'h0, 15'h1234, 6'd3}, {11'h0, vaddr});
    @(posedge pclk);
    irq_src[3]  <= 1'b0;
    irq_src[20] <= 1'b1;
    settle();
    chk("fast_sel", 32'h1, {31'h0, fast_sel});
    chk("fast_vec", {11'h0, 5'h1f, 16'habcd}, {11'h0, vaddr});
    apb(1'b0, pia_pkg::IDX_CTRL, 32'h0);
    chk("ctrl_fast", 32'hf, rd);
    // Service level 2, then only a level 0 request remains
    pulse(1'b1);
    irq_src[20] <= 1'b0;
    settle();
    chk("nest_block", 32'h0, {31'h0, valid});
    chk("fast_mode", 32'h1, {31'h0, fast_mode});
    pulse(1'b0);
    settle();
    chk("nest_resume", 32'h1, {31'h0, valid});
    chk("fast_end", 32'h0, {31'h0, fast_mode});
    // Wake-up with sources 9 and 12 enabled before entry
    @(posedge pclk);
    low_power <= 1'b1;
    settle();
    chk("wake_req", 32'h1, {31'h0, wake_req});
    chk("irq_out", 32'h1, {31'h0, irq_out});
    @(posedge pclk);
    low_power <= 1'b0;
    settle();
    apb(1'b0, pia_pkg::IDX_ISTAT, 32'h0);
    chk("istat_wake", 32'h1, {31'h0, rd[pia_pkg::ST_WAKE]});
    apb(1'b0, pia_pkg::IDX_ISTAT, 32'h0);
    chk("istat_clr", 32'h0, {31'h0, rd[pia_pkg::ST_WAKE]});
    // Disable sources 9 and 12: no offer, no wake, pending kept
    apb(1'b1, pia_pkg::IDX_PRIO_0 + 7'h1, 32'h0000);
    settle();
    chk("dis_valid", 32'h0, {31'h0, valid});
    apb(1'b0, pia_pkg::IDX_PEND_0, 32'h0);
    chk("dis_pend", 32'h1, {31'h0, rd[9]});
    low_power <= 1'b1;
    settle();
    chk("dis_wake", 32'h0, {31'h0, wake_req});
    // Enabled only after entry: offered again, but no wake
    apb(1'b1, pia_pkg::IDX_PRIO_0 + 7'h1, 32'h0104);
    settle();
    chk("reen_valid", 32'h1, {31'h0, valid});
    chk("reen_wake", 32'h0, {31'h0, wake_req});
    close_out();
  end
endmodule : test_priority_interrupt_arbiter
`default_nettype wire
